// ===== src/ffp_params.svh
`ifndef FFP_PARAMS_SVH
`define FFP_PARAMS_SVH
// register indices, byte address is four times the index
`define FFP_IDX_CFG      4'h4
`define FFP_IDX_IRQCFG   4'h5
`define FFP_IDX_STAT     4'h6
`define FFP_IDX_FAULT    4'h7
`define FFP_IDX_PROT     4'h8
// field positions
`define FFP_BIT_IGN      0
`define FFP_BIT_SGL      0
`define FFP_BIT_DBL      1
`define FFP_BIT_VIOL     4
// reset values and the value loaded on a configuration double fault
`define FFP_RST_PROT     8'h00
`define FFP_RST_FLAGS    2'h0
`define FFP_FULL_PROT    8'h7F
// protection configuration byte location
`define FFP_CFG_BYTE_ADR 18'h3_FF0C
// window bounds
`define FFP_HI_START0    18'h3_F800
`define FFP_HI_START1    18'h3_F000
`define FFP_HI_START2    18'h3_E000
`define FFP_HI_START3    18'h3_C000
`define FFP_HI_END       18'h3_FFFF
`define FFP_LO_START     18'h3_8000
`define FFP_LO_END0      18'h3_83FF
`define FFP_LO_END1      18'h3_87FF
`define FFP_LO_END2      18'h3_8FFF
`define FFP_LO_END3      18'h3_9FFF
// allowed scenario moves, bit (from*8+to)
`define FFP_TRANS_OK     64'hFF5A_3C18_080C_0A0F
`endif

// ===== src/ffp_pkg.sv
package ffp_pkg;
	// protection register layout
	typedef struct packed {
		logic       op_en;
		logic       rsv_nv;
		logic       hi_dis;
		logic [1:0] hi_size;
		logic       lo_dis;
		logic [1:0] lo_size;
	} ffp_prot_t;

	// program or erase request from the memory controller
	typedef struct packed {
		logic        is_pflash;
		logic        blk_erase;
		logic [17:0] addr;
	} ffp_cmd_t;

	// read outcome reported by the array read path
	typedef struct packed {
		logic sbe;
		logic dbe;
		logic collide;
	} ffp_rd_evt_t;
endpackage : ffp_pkg

// ===== src/ffp_top.sv
// The address map and the Wishbone slave port were chosen for this implementation.
`include "ffp_params.svh"

module ffp_top #(
	parameter int ADDR_W = 6
) (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic                ce,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  ffp_pkg::ffp_rd_evt_t     rd_evt,
	input  wire logic                cfg_load,
	input  wire logic [7:0]          cfg_byte,
	input  wire logic                cfg_dbe,
	input  wire logic                cmd_req,
	input  ffp_pkg::ffp_cmd_t        cmd,
	output logic                     cmd_done,
	output logic                     cmd_refused,
	output ffp_pkg::ffp_prot_t       prot_o,
	output logic                     irq_fault
);
	import ffp_pkg::*;

	// refuse address widths that cannot reach every register
	if (ADDR_W < 6) begin : g_chk
		$error("ffp_top: ADDR_W must be at least 6");
	end

	logic            rst_m_r;
	logic            rst_sync_n;
	logic            ack_r;
	logic [31:0]     rdat_r;
	logic            ign_r;
	logic [1:0]      irqen_r;
	logic            sgl_r;
	logic            dbl_r;
	logic            viol_r;
	ffp_prot_t       prot_r;
	logic            done_r;
	logic            refused_r;
	logic [3:0]      idx;
	logic            req;
	logic            adr_ok;
	logic            wr_fire;
	logic            sgl_set;
	logic            dbl_set;
	logic            sgl_clr;
	logic            dbl_clr;
	logic            viol_clr;
	ffp_prot_t       wr_prot;
	ffp_prot_t       prot_nxt;
	logic [2:0]      scen_cur;
	logic [2:0]      scen_new;
	logic            trans_ok;
	logic            prot_wr;
	logic [17:0]     hi_start;
	logic [17:0]     lo_end;
	logic            in_hi;
	logic            in_lo;
	logic            in_win;
	logic            addr_prot;
	logic            any_prot;
	logic            refuse;
	logic [63:0]     trans_tab;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_r    <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_m_r    <= 1'b1;
			rst_sync_n <= rst_m_r;
		end
	end

	// bus decode
	assign idx     = wb_adr_i[5:2];
	assign req     = wb_cyc_i & wb_stb_i;
	assign adr_ok  = (wb_adr_i >> 6) == '0; // address bits above the register window must be zero
	assign wr_fire = req & wb_we_i & ack_r & wb_sel_i[0] & adr_ok;

	// classic single cycle ack, dropped the cycle after it is given
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ack_r <= 1'b0;
		end else if (ce) begin
			ack_r <= req & ~ack_r;
		end
	end

	// read data captured as the ack is raised; unmapped reads zero
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdat_r <= 32'h0000_0000;
		end else if (ce && req && !ack_r) begin
			rdat_r <= 32'h0000_0000;
			if (adr_ok) begin
				unique case (idx)
					`FFP_IDX_CFG:    rdat_r[`FFP_BIT_IGN]  <= ign_r;
					`FFP_IDX_IRQCFG: rdat_r[1:0]           <= irqen_r;
					`FFP_IDX_STAT:   rdat_r[`FFP_BIT_VIOL] <= viol_r;
					`FFP_IDX_FAULT:  rdat_r[1:0]           <= {dbl_r, sgl_r};
					`FFP_IDX_PROT:   rdat_r[7:0]           <= prot_r;
					default:         rdat_r                <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// configuration and interrupt enable registers
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ign_r   <= 1'b0;
			irqen_r <= 2'h0;
		end else if (ce && wr_fire) begin
			if (idx == `FFP_IDX_CFG) begin
				ign_r <= wb_dat_i[`FFP_BIT_IGN];
			end
			if (idx == `FFP_IDX_IRQCFG) begin
				irqen_r <= wb_dat_i[1:0];
			end
		end
	end

	// fault flag set and clear terms
	assign sgl_set = rd_evt.collide | (rd_evt.sbe & ~rd_evt.dbe & ~ign_r);
	assign dbl_set = rd_evt.collide | rd_evt.dbe;
	assign sgl_clr = wr_fire & (idx == `FFP_IDX_FAULT) & wb_dat_i[`FFP_BIT_SGL];
	assign dbl_clr = wr_fire & (idx == `FFP_IDX_FAULT) & wb_dat_i[`FFP_BIT_DBL];

	// sticky fault flags, a set in the clear cycle wins
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{dbl_r, sgl_r} <= `FFP_RST_FLAGS;
		end else if (ce) begin
			sgl_r <= (sgl_r & ~sgl_clr) | sgl_set;
			dbl_r <= (dbl_r & ~dbl_clr) | dbl_set;
		end
	end

	// interrupt request per enabled flag
	assign irq_fault = (dbl_r & irqen_r[1]) | (sgl_r & irqen_r[0]);

	// scenario check on a protection write
	assign trans_tab = `FFP_TRANS_OK;
	assign wr_prot   = ffp_prot_t'(wb_dat_i[7:0]);
	assign scen_cur  = {prot_r.op_en, prot_r.hi_dis, prot_r.lo_dis};
	assign scen_new  = {wr_prot.op_en, wr_prot.hi_dis, wr_prot.lo_dis};
	assign trans_ok  = trans_tab[{scen_cur, scen_new}];
	assign prot_wr   = wr_fire & (idx == `FFP_IDX_PROT) & trans_ok;

	// accepted value, size fields only move while their window is disabled
	always_comb begin
		prot_nxt         = prot_r;
		prot_nxt.op_en   = wr_prot.op_en;
		prot_nxt.hi_dis  = wr_prot.hi_dis;
		prot_nxt.lo_dis  = wr_prot.lo_dis;
		if (prot_r.hi_dis) begin
			prot_nxt.hi_size = wr_prot.hi_size;
		end
		if (prot_r.lo_dis) begin
			prot_nxt.lo_size = wr_prot.lo_size;
		end
	end

	// protection register, reset load takes priority over software
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prot_r <= ffp_prot_t'(`FFP_RST_PROT);
		end else if (ce) begin
			if (cfg_load) begin
				if (cfg_dbe) begin
					prot_r <= ffp_prot_t'(`FFP_FULL_PROT);
				end else begin
					prot_r <= ffp_prot_t'(cfg_byte);
				end
			end else if (prot_wr) begin
				prot_r <= prot_nxt;
			end
		end
	end

	assign prot_o = prot_r;

	// window bounds from size codes
	always_comb begin
		unique case (prot_r.hi_size)
			2'b00: hi_start = `FFP_HI_START0;
			2'b01: hi_start = `FFP_HI_START1;
			2'b10: hi_start = `FFP_HI_START2;
			2'b11: hi_start = `FFP_HI_START3;
		endcase
		unique case (prot_r.lo_size)
			2'b00: lo_end = `FFP_LO_END0;
			2'b01: lo_end = `FFP_LO_END1;
			2'b10: lo_end = `FFP_LO_END2;
			2'b11: lo_end = `FFP_LO_END3;
		endcase
	end

	// address classification against the enabled windows
	assign in_hi  = ~prot_r.hi_dis & (cmd.addr >= hi_start) & (cmd.addr <= `FFP_HI_END);
	assign in_lo  = ~prot_r.lo_dis & (cmd.addr >= `FFP_LO_START) & (cmd.addr <= lo_end);
	assign in_win = in_hi | in_lo;
	// windows protect at op 1 and exempt at op 0
	assign addr_prot = prot_r.op_en ? in_win : ~in_win;
	// only op 1 with both windows off leaves the block bare
	assign any_prot  = ~(prot_r.op_en & prot_r.hi_dis & prot_r.lo_dis);
	assign refuse    = cmd.is_pflash & (cmd.blk_erase ? any_prot : addr_prot);

	// command verdict, one cycle after the request
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			done_r    <= 1'b0;
			refused_r <= 1'b0;
		end else if (ce) begin
			done_r    <= cmd_req;
			refused_r <= cmd_req & refuse;
		end
	end

	assign cmd_done    = done_r;
	assign cmd_refused = refused_r;

	// protection violation flag, set wins over clear
	assign viol_clr = wr_fire & (idx == `FFP_IDX_STAT) & wb_dat_i[`FFP_BIT_VIOL];

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			viol_r <= 1'b0;
		end else if (ce) begin
			viol_r <= (viol_r & ~viol_clr) | (cmd_req & refuse);
		end
	end

	// checks on the flags and protection
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_sync_n);

	a_dbl_set_on_fault: assert property (
		ce && (rd_evt.dbe || rd_evt.collide) |=> dbl_r && irq_fault == (irqen_r[1] || (sgl_r && irqen_r[0])))
		else $error("double fault flag not set on fault");

	a_dbl_w1c_clear: assert property (
		ce && dbl_clr && !rd_evt.dbe && !rd_evt.collide |=> !dbl_r)
		else $error("double fault flag not cleared by write one");

	a_sgl_ignored: assert property (
		ce && ign_r && !sgl_r && !rd_evt.collide |=> !sgl_r)
		else $error("single fault flag set while ignored");

	a_ecc_exclusive: assert property (
		ce && rd_evt.sbe && rd_evt.dbe && !rd_evt.collide && !sgl_r |=> !sgl_r && dbl_r)
		else $error("single and double flags both set by one fault");

	a_collide_both: assert property (
		ce && rd_evt.collide |=> sgl_r && dbl_r)
		else $error("collision did not set both flags");

	a_prot_bad_write: assert property (
		ce && wr_fire && idx == `FFP_IDX_PROT && !trans_ok && !cfg_load |=> $stable(prot_r))
		else $error("invalid protection write changed the register");

	a_hsize_locked: assert property (
		ce && !cfg_load && !prot_r.hi_dis |=> prot_r.hi_size == $past(prot_r.hi_size))
		else $error("high window size changed while window enabled");

	a_load_dbe_full: assert property (
		ce && cfg_load && cfg_dbe |=> prot_r == ffp_prot_t'(`FFP_FULL_PROT) && !prot_r.op_en)
		else $error("double fault load did not give full protection");

	a_refuse_viol: assert property (
		ce && cmd_req && refuse |=> cmd_done && cmd_refused && viol_r)
		else $error("protected command not refused with violation");

	a_blk_erase: assert property (
		ce && cmd_req && cmd.is_pflash && cmd.blk_erase && any_prot |=> cmd_refused)
		else $error("block erase allowed with protected sectors");

	a_nothing_prot: assert property (
		ce && cmd_req && prot_r.op_en && prot_r.hi_dis && prot_r.lo_dis |=> !cmd_refused)
		else $error("command refused with no protection active");

	a_sgl_set_on_fault: assert property (
		ce && !ign_r && rd_evt.sbe && !rd_evt.dbe |=> sgl_r)
		else $error("single fault flag not set on corrected read");

	a_sgl_w1c_clear: assert property (
		ce && sgl_clr && !rd_evt.collide && !rd_evt.sbe |=> !sgl_r)
		else $error("single fault flag not cleared by write one");

	a_sgl_hold: assert property (
		ce && sgl_r && !sgl_clr |=> sgl_r)
		else $error("single fault flag lost without a clear");

	a_dbl_hold: assert property (
		ce && dbl_r && !dbl_clr |=> dbl_r)
		else $error("double fault flag lost without a clear");

	a_prot_good_write: assert property (
		ce && prot_wr && !cfg_load
		|=> {prot_r.op_en, prot_r.hi_dis, prot_r.lo_dis} == $past({wb_dat_i[7], wb_dat_i[5], wb_dat_i[2]}))
		else $error("allowed protection write not taken");

	a_load_cfg: assert property (
		ce && cfg_load && !cfg_dbe |=> prot_o == $past(cfg_byte))
		else $error("configuration byte not loaded");

	a_lsize_locked: assert property (
		ce && !cfg_load && !prot_r.lo_dis |=> prot_r.lo_size == $past(prot_r.lo_size))
		else $error("low window size changed while window enabled");

	a_prot_readback: assert property (
		ce && req && !ack_r && adr_ok && idx == `FFP_IDX_PROT |=> wb_dat_o[7:0] == $past(prot_r))
		else $error("protection read does not show the active scenario");

	a_fault_readback: assert property (
		ce && req && !ack_r && adr_ok && idx == `FFP_IDX_FAULT |=> wb_dat_o[1:0] == $past({dbl_r, sgl_r}))
		else $error("fault status read does not show the flags");

	a_irq_dbl: assert property (
		dbl_r && irqen_r[1] |-> irq_fault)
		else $error("enabled double fault gives no interrupt");

	a_irq_quiet: assert property (
		!dbl_r && !sgl_r |-> !irq_fault)
		else $error("interrupt without a fault flag");

	a_hi_protect: assert property (
		ce && cmd_req && cmd.is_pflash && !cmd.blk_erase && prot_r.op_en && !prot_r.hi_dis
		&& cmd.addr >= `FFP_HI_START0 |=> cmd_refused)
		else $error("command in protected high window allowed");

	a_lo_protect: assert property (
		ce && cmd_req && cmd.is_pflash && !cmd.blk_erase && prot_r.op_en && !prot_r.lo_dis
		&& cmd.addr >= `FFP_LO_START && cmd.addr <= `FFP_LO_END0 |=> cmd_refused)
		else $error("command in protected low window allowed");

	a_hi_exempt: assert property (
		ce && cmd_req && cmd.is_pflash && !cmd.blk_erase && !prot_r.op_en && !prot_r.hi_dis
		&& cmd.addr >= `FFP_HI_START0 |=> !cmd_refused)
		else $error("command in unprotected high window refused");

	a_full_prot: assert property (
		ce && cmd_req && cmd.is_pflash && !prot_r.op_en && prot_r.hi_dis && prot_r.lo_dis |=> cmd_refused)
		else $error("command allowed under full protection");

	a_other_free: assert property (
		ce && cmd_req && !cmd.is_pflash |=> cmd_done && !cmd_refused)
		else $error("command outside program flash refused");

endmodule : ffp_top

// ===== test/test_ffp_top.sv
module test_ffp_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ffp_pkg::*;

	// allowed scenario moves, one byte per source scenario, bit per target
	localparam logic [63:0] MOVES  = 64'hFF5A_3C18_080C_0A0F;
	localparam logic [17:0] HI_ST [4] = '{18'h3_F800, 18'h3_F000, 18'h3_E000, 18'h3_C000};
	localparam logic [17:0] LO_END [4] = '{18'h3_83FF, 18'h3_87FF, 18'h3_8FFF, 18'h3_9FFF};

	logic        clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ce = 1;
	logic [5:0]  adr = '0;
	logic [31:0] wdat = '0, rdat, dat_o;
	logic        ack, cfg_load = 0, cfg_dbe = 0, cmd_req = 0, cmd_done, cmd_refused, irq;
	logic [7:0]  cfg_byte = '0;
	ffp_rd_evt_t rd_evt = '0;
	ffp_cmd_t    cmd = '0;
	ffp_prot_t   prot;
	int          fails = 0, comparisons = 0, cycles = 0, seed = 77;

	ffp_top #(.ADDR_W(6)) ffp_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rd_evt(rd_evt), .cfg_load(cfg_load), .cfg_byte(cfg_byte), .cfg_dbe(cfg_dbe),
		.cmd_req(cmd_req), .cmd(cmd), .cmd_done(cmd_done), .cmd_refused(cmd_refused), .prot_o(prot),
		.irq_fault(irq));

	// clock and hang guard
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// classic single wishbone cycle, entered right after a rising edge
	task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		@(posedge clk_sys);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		check(ack, 1, "bus ack");
		rdat = dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_sys);
	endtask : bus

	task automatic load_cfg(input logic [7:0] b, input logic dbe);
		cfg_load <= 1;
		cfg_byte <= b;
		cfg_dbe <= dbe;
		@(posedge clk_sys);
		cfg_load <= 0;
		@(posedge clk_sys);
	endtask : load_cfg

	task automatic run_cmd(input logic [19:0] c, input logic exp);
		cmd_req <= 1;
		cmd <= c;
		@(posedge clk_sys);
		cmd_req <= 0;
		#1;
		check(cmd_done, 1, "cmd done");
		check(cmd_refused, exp, "cmd refused");
		@(posedge clk_sys);
	endtask : run_cmd

	// register value after a software write, scenario is {op,hi_dis,lo_dis}
	function automatic logic [7:0] prot_next(input logic [7:0] o, input logic [7:0] w);
		if (!MOVES[{o[7], o[5], o[2], w[7], w[5], w[2]}]) return o;
		return {w[7], o[6], w[5], o[5] ? w[4:3] : o[4:3], w[2], o[2] ? w[1:0] : o[1:0]};
	endfunction : prot_next

	function automatic logic is_prot(input logic [7:0] p, input logic [17:0] a, input logic be);
		logic hit;
		if (be) return {p[7], p[5], p[2]} != 3'd7;
		hit = (!p[5] && a >= HI_ST[p[4:3]]) || (!p[2] && a >= 18'h3_8000 && a <= LO_END[p[1:0]]);
		return p[7] ? hit : !hit;
	endfunction : is_prot

	initial begin
		logic [7:0]  o, w;
		logic [17:0] a;
		logic [1:0]  fl, en;
		logic        pf, be;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1;
		repeat (3) @(posedge clk_sys);
		check(prot, 8'h00, "prot reset");
		bus(0, 4'h7, 0);
		check(rdat, 0, "flags reset");
		bus(1, 4'hF, 8'hFF);
		bus(0, 4'hF, 0);
		check(rdat, 0, "unmapped read");
		load_cfg(8'hE5, 0);
		check(prot, 8'hE5, "cfg load");
		load_cfg(8'hE5, 1);
		check(prot, 8'h7F, "cfg double fault");
		// every scenario pair, random size bits, reserved bit held at one
		for (int i = 0; i < 64; i++) begin
			o = $random(seed);
			w = $random(seed);
			{o[7], o[5], o[2], w[7], w[5], w[2]} = i[5:0];
			o[6] = 1'b1;
			w[6] = 1'b1;
			load_cfg(o, 0);
			bus(1, 4'h8, w);
			bus(0, 4'h8, 0);
			check(rdat, prot_next(o, w), "prot write");
		end
		// read faults with ignore bit and irq enables
		for (int k = 0; k < 8; k++) begin
			en = $random(seed);
			bus(1, 4'h4, {7'h0, k[2]});
			bus(1, 4'h5, {6'h0, en});
			rd_evt <= k[1:0] == 0 ? 3'b100 : k[1:0] == 1 ? 3'b010 : k[1:0] == 2 ? 3'b001 : 3'b110;
			@(posedge clk_sys);
			rd_evt <= '0;
			@(posedge clk_sys);
			fl = k[1:0] == 2 ? 2'b11 : k[1:0] == 0 ? {1'b0, !k[2]} : 2'b10;
			bus(0, 4'h7, 0);
			check(rdat, fl, "fault flags");
			check(irq, |(fl & en), "irq level");
			bus(1, 4'h7, 8'h00);
			bus(0, 4'h7, 0);
			check(rdat, fl, "flags after zero write");
			bus(1, 4'h7, 8'h03);
			bus(0, 4'h7, 0);
			check(rdat, 0, "flags cleared");
		end
		// clock enable low freezes the flags
		ce <= 0;
		rd_evt <= 3'b001;
		@(posedge clk_sys);
		rd_evt <= '0;
		ce <= 1;
		@(posedge clk_sys);
		bus(0, 4'h7, 0);
		check(rdat, 0, "flags frozen by clock enable");
		// program and erase checks, window edges among random addresses
		for (int i = 0; i < 200; i++) begin
			o = $random(seed);
			o[6] = 1'b1;
			a = 18'h3_8000 + 18'($unsigned($random(seed)) & 32'h7FFF);
			if (i[0]) a = i[1] ? HI_ST[i[3:2]] - 18'(i[4]) : LO_END[i[3:2]] + 18'(i[4]);
			pf = i % 16 != 0;
			be = i % 8 == 3;
			load_cfg(o, 0);
			run_cmd({pf, be, a}, pf && is_prot(o, a, be));
		end
		bus(1, 4'h6, 8'h10);
		load_cfg(8'h64, 0);
		run_cmd({2'b10, 18'h3_8000}, 1);
		bus(0, 4'h6, 0);
		check(rdat & 32'h10, 32'h10, "violation flag");
		bus(1, 4'h6, 8'h10);
		bus(0, 4'h6, 0);
		check(rdat & 32'h10, 0, "violation cleared");
		conclude();
	end
endmodule : test_ffp_top
